// File: hdl/bfp_positioner.sv
// Bus-loss supervisor and autonomous fail-safe positioning sequencer
`timescale 1ns/1ps
`default_nettype none

module bfp_positioner #(
    parameter int unsigned LOST_FRAMES = bfp_pkg::LOST_FRAMES // Shorten in simulation
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Frame decoder and command events
    input wire logic frame_valid,
    input wire logic dual_position_cmd,
    input wire logic zero_position_cmd,
    // Programmed configuration
    input wire bfp_pkg::bfp_otp_s otp,
    // Strap pin, floating detector output
    input wire logic address_strap_two,
    // Motion core handshake
    input wire logic motion_done,
    input wire logic stall_hit,
    output bfp_pkg::bfp_move_s move,
    output logic [15:0] target_position,
    output logic pos_zero,
    // Supervisor status
    output logic bus_lost,
    output logic sleep_req,
    output logic stop_req,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bfp_pkg::bfp_regs_s r; // Registered state
    bfp_pkg::bfp_regs_s next_r; // Next state
    logic apb_access; // Access phase not yet answered
    logic apb_commit; // Access phase answered: write lands now
    logic lost_evt; // Bus loss detected this cycle
    logic strap_rise; // Strap just went floating

    // Safe position enables a move
    function automatic logic safe_valid(input logic [10:0] pos);
        return pos != bfp_pkg::NO_SAFE_POS;
    endfunction

    // Sign-extend the safe position into a target
    function automatic logic [15:0] safe_target(input logic [10:0] pos);
        return {{5{pos[10]}}, pos};
    endfunction

    // Parking state at the end of a sequence
    function automatic bfp_pkg::bfp_state_e park(input logic allow, input logic strap,
                                                input logic lost);
        // Strap cause or live bus forbids sleep
        if (allow && !strap && lost) begin
            return bfp_pkg::ST_SLEEP;
        end
        return bfp_pkg::ST_STOP;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.move.req = 1'b0;
        next_r.pos_zero = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        lost_evt = 1'b0;
        // Strap synchroniser; the second stage and its one-cycle delayed copy are read
        next_r.strap_s1 = address_strap_two;
        next_r.strap_s2 = r.strap_s1;
        next_r.strap_q = r.strap_s2;
        strap_rise = r.strap_s2 && !r.strap_q;
        apb_access = psel && penable && !r.pready;
        apb_commit = psel && penable && pwrite && r.pready;

        // APB first, so hardware sets below win over clears
        if (apb_access) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            unique case (paddr)
                bfp_pkg::ADDR_STATUS: begin
                    next_r.prdata[bfp_pkg::ST_BIT_LOST] = r.bus_lost;
                    next_r.prdata[bfp_pkg::ST_BIT_REF] = r.referenced;
                    next_r.prdata[bfp_pkg::ST_BIT_STRAP] = r.strap_s2;
                    next_r.prdata[bfp_pkg::ST_BIT_BUSY] = r.state inside {bfp_pkg::ST_ABS,
                        bfp_pkg::ST_REF, bfp_pkg::ST_ZERO, bfp_pkg::ST_CONFIRM};
                    next_r.prdata[bfp_pkg::ST_BIT_SLEEP] = r.park_sleep;
                    next_r.prdata[bfp_pkg::ST_BIT_STOP] = r.park_stop;
                end
                bfp_pkg::ADDR_SAFE_POS: begin
                    next_r.prdata[10:0] = r.safe_pos;
                end
                bfp_pkg::ADDR_TARGET: begin
                    next_r.prdata[15:0] = r.target_position;
                end
                bfp_pkg::ADDR_IRQ_STAT: begin
                    next_r.prdata[2:0] = r.irq_stat;
                end
                bfp_pkg::ADDR_IRQ_MASK: begin
                    next_r.prdata[2:0] = r.irq_mask;
                end
                default: begin
                    // Unmapped: error, read zero
                    next_r.pslverr = 1'b1;
                end
            endcase
        end

        // A write lands only at the edge where the master sees pready
        if (apb_commit) begin
            unique case (paddr)
                bfp_pkg::ADDR_SAFE_POS: begin
                    // Master may update the working copy
                    next_r.safe_pos = pwdata[10:0];
                end
                bfp_pkg::ADDR_IRQ_STAT: begin
                    // Write one to clear
                    next_r.irq_stat = r.irq_stat & ~pwdata[2:0];
                end
                bfp_pkg::ADDR_IRQ_MASK: begin
                    next_r.irq_mask = pwdata[2:0];
                end
                default: begin
                    // Read-only or unmapped: nothing to store
                end
            endcase
        end

        // Frame slot timer and silence counter
        if (frame_valid) begin
            next_r.frame_div = 10'h000;
            next_r.frame_cnt = 15'h0000;
            next_r.seen_frame = 1'b1;
            next_r.bus_lost = 1'b0;
        end else if (r.frame_div == 10'(bfp_pkg::FRAME_CYC - 1)) begin
            next_r.frame_div = 10'h000;
            if (!r.bus_lost) begin
                if (r.frame_cnt == 15'(LOST_FRAMES - 1)) begin
                    next_r.bus_lost = 1'b1;
                    lost_evt = 1'b1;
                end else begin
                    next_r.frame_cnt = r.frame_cnt + 15'h0001;
                end
            end
        end else begin
            next_r.frame_div = r.frame_div + 10'h001;
        end

        // Referenced by dual positioning or zeroing command
        if (dual_position_cmd || zero_position_cmd) begin
            next_r.referenced = 1'b1;
        end

        // Fail-safe sequencer
        unique case (r.state)
            bfp_pkg::ST_BOOT: begin
                // Nine MSBs only; two LSBs read zero
                next_r.safe_pos = {otp.safe_pos[10:2], 2'b00};
                next_r.state = bfp_pkg::ST_IDLE;
            end
            bfp_pkg::ST_IDLE, bfp_pkg::ST_STOP, bfp_pkg::ST_SLEEP: begin
                // A parked unit wakes when frames return
                if (r.state != bfp_pkg::ST_IDLE && frame_valid) begin
                    next_r.state = bfp_pkg::ST_IDLE;
                end else if (r.state == bfp_pkg::ST_IDLE && (lost_evt || strap_rise)) begin
                    next_r.cause_strap = !lost_evt;
                    next_r.startup_case = !r.seen_frame;
                    next_r.issued = 1'b0;
                    if (!r.seen_frame) begin
                        // Lost at or before power-up
                        if (otp.safe_motion && safe_valid(r.safe_pos)) begin
                            next_r.state = bfp_pkg::ST_REF;
                        end else if (!otp.safe_motion && safe_valid(r.safe_pos)) begin
                            next_r.state = bfp_pkg::ST_ABS;
                        end else begin
                            next_r.state = park(otp.sleep_allow, !lost_evt, next_r.bus_lost);
                        end
                    end else if (r.referenced) begin
                        // Safe-motion bit plays no part here
                        if (safe_valid(r.safe_pos)) begin
                            next_r.state = bfp_pkg::ST_ABS;
                        end else begin
                            next_r.state = park(otp.sleep_allow, !lost_evt, next_r.bus_lost);
                        end
                    end else if (otp.safe_motion && safe_valid(r.safe_pos)) begin
                        next_r.state = bfp_pkg::ST_REF;
                    end else begin
                        next_r.state = park(otp.sleep_allow, !lost_evt, next_r.bus_lost);
                    end
                    if (next_r.state inside {bfp_pkg::ST_STOP, bfp_pkg::ST_SLEEP}) begin
                        next_r.irq_stat[bfp_pkg::IRQ_DONE] = 1'b1;
                    end
                end
            end
            bfp_pkg::ST_ABS: begin
                // Absolute move to the working safe position
                if (!r.issued) begin
                    next_r.issued = 1'b1;
                    next_r.target_position = safe_target(r.safe_pos);
                    next_r.move.req = 1'b1;
                    next_r.move.absolute = 1'b1;
                    next_r.move.negative = r.safe_pos[10] ^ otp.shaft;
                    next_r.move.otp_params = 1'b1;
                    next_r.move.steps = 16'h0000;
                end else if (motion_done) begin
                    next_r.issued = 1'b0;
                    // Live frame now forbids sleep
                    next_r.state = park(otp.sleep_allow, r.cause_strap, next_r.bus_lost);
                    next_r.irq_stat[bfp_pkg::IRQ_DONE] = 1'b1;
                end
            end
            bfp_pkg::ST_REF: begin
                // Negative half-range run, ended by stall
                if (!r.issued) begin
                    next_r.issued = 1'b1;
                    next_r.move.req = 1'b1;
                    next_r.move.absolute = 1'b0;
                    next_r.move.negative = !otp.shaft;
                    next_r.move.otp_params = 1'b1;
                    next_r.move.steps = bfp_pkg::HALF_RANGE_STEPS;
                end else if (stall_hit || motion_done) begin
                    next_r.issued = 1'b0;
                    next_r.state = bfp_pkg::ST_ZERO;
                end
            end
            bfp_pkg::ST_ZERO: begin
                // End-stop is the new origin
                next_r.pos_zero = 1'b1;
                next_r.referenced = 1'b1;
                if (r.startup_case) begin
                    // Start-up goes straight on to the safe move
                    next_r.state = safe_valid(r.safe_pos) ? bfp_pkg::ST_ABS :
                        park(otp.sleep_allow, r.cause_strap, next_r.bus_lost);
                end else begin
                    next_r.state = bfp_pkg::ST_CONFIRM;
                end
            end
            bfp_pkg::ST_CONFIRM: begin
                // Ten more steps into the stop to be sure
                if (!r.issued) begin
                    next_r.issued = 1'b1;
                    next_r.move.req = 1'b1;
                    next_r.move.absolute = 1'b0;
                    next_r.move.negative = !otp.shaft;
                    next_r.move.otp_params = 1'b1;
                    next_r.move.steps = bfp_pkg::CONFIRM_STEPS;
                end else if (stall_hit || motion_done) begin
                    next_r.issued = 1'b0;
                    next_r.state = safe_valid(r.safe_pos) ? bfp_pkg::ST_ABS :
                        park(otp.sleep_allow, r.cause_strap, next_r.bus_lost);
                end
            end
            default: begin
                next_r.state = bfp_pkg::ST_IDLE;
            end
        endcase

        // Sticky events set last so they win over a clear
        if (lost_evt) begin
            next_r.irq_stat[bfp_pkg::IRQ_LOST] = 1'b1;
        end
        if (strap_rise) begin
            next_r.irq_stat[bfp_pkg::IRQ_STRAP] = 1'b1;
        end
        next_r.park_sleep = next_r.state == bfp_pkg::ST_SLEEP;
        next_r.park_stop = next_r.state == bfp_pkg::ST_STOP;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.state <= bfp_pkg::ST_BOOT;
            r.safe_pos <= bfp_pkg::SAFE_POS_RST;
            r.irq_mask <= bfp_pkg::IRQ_MASK_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign move = r.move;
    assign target_position = r.target_position;
    assign pos_zero = r.pos_zero;
    assign bus_lost = r.bus_lost;
    assign sleep_req = r.park_sleep;
    assign stop_req = r.park_stop;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_lost_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!frame_valid && !r.bus_lost && r.frame_cnt == 15'(LOST_FRAMES - 1)
         && r.frame_div == 10'(bfp_pkg::FRAME_CYC - 1)) |=> r.bus_lost && r.irq_stat[0])
        else $error("bus loss not flagged at frame limit");
    chk_frame_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        frame_valid |=> r.frame_cnt == 15'h0000 && !r.bus_lost)
        else $error("valid frame did not clear silence count");
    chk_sleep_allow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(r.park_sleep) |-> otp.sleep_allow && r.bus_lost)
        else $error("sleep entered without permission");
    chk_strap_sleep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.cause_strap && r.state != bfp_pkg::ST_IDLE |-> !r.park_sleep)
        else $error("strap-caused fail-safe entered sleep");
    chk_ref_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (r.state != bfp_pkg::ST_REF ##1 r.state == bfp_pkg::ST_REF)
        |-> $past(otp.safe_motion) && safe_valid($past(r.safe_pos)))
        else $error("reference run without safe-motion");
    chk_abs_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_ABS && !r.issued
        |=> r.move.req && r.move.absolute && r.target_position == safe_target($past(r.safe_pos)))
        else $error("safe position not copied to target");
    chk_skip_safe: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_ABS && !r.issued |-> safe_valid(r.safe_pos))
        else $error("secure move issued for disabled position");
    chk_zero_confirm: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_ZERO && !r.startup_case
        |=> r.pos_zero && r.referenced ##1 r.move.req && r.move.steps == 16'h000A)
        else $error("zeroing or confirm move missing");
    chk_boot_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_BOOT |=> r.safe_pos == {$past(otp.safe_pos[10:2]), 2'b00})
        else $error("startup safe position load wrong");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.irq == |(r.irq_stat & r.irq_mask))
        else $error("interrupt line disagrees with status");
    chk_apb_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
        psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    chk_ref_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_REF && !r.issued
        |=> r.move.req && !r.move.absolute && r.move.negative == !otp.shaft && r.move.otp_params)
        else $error("reference run issued with wrong direction");
    chk_abs_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.state == bfp_pkg::ST_ABS && !r.issued
        |=> r.move.negative == ($past(r.safe_pos[10]) ^ otp.shaft))
        else $error("secure move issued with wrong direction");

endmodule // bfp_positioner

`default_nettype wire

// File: pkg/bfp_pkg.sv
// Package of constants and types for the bus-loss fail-safe positioner
package bfp_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000; // System clock rate
    localparam int unsigned FRAME_TIME_NS = 52_000; // One frame slot
    // Frame slot in cycles, rounded down
    localparam int unsigned FRAME_CYC = (FRAME_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned LOST_FRAMES = 25000; // Silent frames to bus loss
    // ------------------------------------------------------------
    // Motion constants
    // ------------------------------------------------------------
    localparam logic [10:0] NO_SAFE_POS = 11'h400; // Disables safe move
    localparam logic [15:0] CONFIRM_STEPS = 16'h000A; // Ten full steps
    localparam logic [15:0] HALF_RANGE_STEPS = 16'h4000; // Half travel
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SAFE_POS = 8'h04;
    localparam logic [7:0] ADDR_TARGET = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam int ST_BIT_LOST = 0;
    localparam int ST_BIT_REF = 1;
    localparam int ST_BIT_STRAP = 2;
    localparam int ST_BIT_BUSY = 3;
    localparam int ST_BIT_SLEEP = 4;
    localparam int ST_BIT_STOP = 5;
    localparam int IRQ_LOST = 0; // Bus-lost event
    localparam int IRQ_DONE = 1; // Fail-safe sequence finished
    localparam int IRQ_STRAP = 2; // Strap went floating
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic [10:0] SAFE_POS_RST = 11'h400;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_BOOT, ST_IDLE, ST_ABS, ST_REF, ST_ZERO, ST_CONFIRM, ST_STOP, ST_SLEEP
    } bfp_state_e;
    // Programmed configuration bits
    typedef struct packed {
        logic sleep_allow;
        logic safe_motion;
        logic shaft;
        logic [10:0] safe_pos;
    } bfp_otp_s;
    // Command to the motion core
    typedef struct packed {
        logic req;
        logic absolute;
        logic negative;
        logic otp_params;
        logic [15:0] steps;
    } bfp_move_s;
    // Whole state of the positioner
    typedef struct packed {
        bfp_state_e state;
        logic [9:0] frame_div;
        logic [14:0] frame_cnt;
        logic bus_lost;
        logic seen_frame;
        logic referenced;
        logic cause_strap;
        logic startup_case;
        logic issued;
        logic strap_s1;
        logic strap_s2;
        logic strap_q;
        logic [10:0] safe_pos;
        logic [15:0] target_position;
        bfp_move_s move;
        logic pos_zero;
        logic park_sleep;
        logic park_stop;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bfp_regs_s;
endpackage

// File: tb/bfp_motion_model.sv
// Behavioural motion core that answers the positioner's move requests
`timescale 1ns/1ps
`default_nettype none
module bfp_motion_model #(
    parameter int DLY = 20 // Cycles a move takes
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Requests from the positioner
    input wire bfp_pkg::bfp_move_s move,
    input wire logic [15:0] target_position,
    input wire logic pos_zero,
    // Answers
    output logic motion_done,
    output logic stall_hit
);
    bfp_pkg::bfp_move_s log_q[$]; // Every request seen
    logic [15:0] tgt_q[$]; // Target seen at each answer
    bfp_pkg::bfp_move_s cur;
    int cnt;
    int n_zero;
    // A half-range relative run ends in a stall, anything else just finishes
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            motion_done <= 1'b0;
            stall_hit <= 1'b0;
            cnt = 0;
            n_zero = 0;
            log_q.delete();
            tgt_q.delete();
        end else begin
            motion_done <= 1'b0;
            stall_hit <= 1'b0;
            n_zero += int'(pos_zero === 1'b1);
            if (move.req === 1'b1) begin
                cur = move;
                cnt = DLY;
                log_q.push_back(move);
            end else if (cnt > 1) begin
                cnt--;
            end else if (cnt == 1) begin
                cnt = 0;
                tgt_q.push_back(target_position);
                if (!cur.absolute && cur.steps == bfp_pkg::HALF_RANGE_STEPS) stall_hit <= 1'b1;
                else motion_done <= 1'b1;
            end
        end
    end
endmodule // bfp_motion_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the bus-loss fail-safe positioner
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, frame_valid = 1'b0, dual_cmd = 1'b0, strap = 1'b0, zero_cmd = 1'b0;
    logic motion_done, stall_hit, pos_zero, bus_lost, sleep_req, stop_req, irq, bus_on = 1'b0;
    logic [6:0] fdiv = 7'h00;
    logic [15:0] target_position;
    bfp_pkg::bfp_otp_s otp = '0;
    bfp_pkg::bfp_move_s move;
    int errors = 0, n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    // Bus master frames every 128 cycles while talking
    always @(posedge clk_sys) begin
        fdiv <= fdiv + 7'h01;
        frame_valid <= bus_on && fdiv == 7'h00;
    end
    bfp_positioner #(.LOST_FRAMES(4)) bfp_positioner_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid),
        .dual_position_cmd(dual_cmd), .zero_position_cmd(zero_cmd), .otp(otp),
        .address_strap_two(strap), .motion_done(motion_done), .stall_hit(stall_hit),
        .move(move), .target_position(target_position), .pos_zero(pos_zero),
        .bus_lost(bus_lost), .sleep_req(sleep_req), .stop_req(stop_req), .irq(irq));
    bfp_motion_model bfp_motion_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .move(move),
        .target_position(target_position), .pos_zero(pos_zero),
        .motion_done(motion_done), .stall_hit(stall_hit));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic restart(input bfp_pkg::bfp_otp_s o);
        bus_on <= 1'b0;
        rst_b <= 1'b0;
        otp <= o;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask
    task automatic wait_park;
        do @(posedge clk_sys); while (stop_req !== 1'b1 && sleep_req !== 1'b1);
    endtask
    // Compare one logged move: steps for runs, target for absolute moves
    task automatic chk_mv(input int i, input logic a, input logic n, input logic [15:0] v);
        chk({31'h0, bfp_motion_model_inst.log_q[i].absolute}, {31'h0, a});
        chk({31'h0, bfp_motion_model_inst.log_q[i].negative}, {31'h0, n});
        chk({16'h0, a ? bfp_motion_model_inst.tgt_q[i] : bfp_motion_model_inst.log_q[i].steps}, {16'h0, v});
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        restart({1'b1, 1'b1, 1'b0, 11'h0FF});
        apb(1'b0, bfp_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, bfp_pkg::ADDR_SAFE_POS, 32'h0);
        chk(rd, 32'h0FC);
        apb(1'b0, bfp_pkg::ADDR_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        wait_park;
        chk(bfp_motion_model_inst.log_q.size(), 32'h2);
        chk_mv(0, 1'b0, 1'b1, bfp_pkg::HALF_RANGE_STEPS);
        chk_mv(1, 1'b1, 1'b0, 16'h00FC);
        chk({30'h0, sleep_req, stop_req}, 32'h2);
        $display("startup reference test done");
        restart({1'b0, 1'b0, 1'b1, 11'h7F0});
        wait_park;
        chk(bfp_motion_model_inst.log_q.size(), 32'h1);
        chk_mv(0, 1'b1, 1'b0, 16'hFFF0);
        chk({30'h0, sleep_req, stop_req}, 32'h1);
        apb(1'b0, bfp_pkg::ADDR_TARGET, 32'h0);
        chk(rd, 32'h0000_FFF0);
        apb(1'b0, bfp_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h21);
        zero_cmd <= 1'b1;
        @(posedge clk_sys);
        zero_cmd <= 1'b0;
        apb(1'b0, bfp_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h23);
        $display("startup absolute test done");
        restart({1'b1, 1'b1, 1'b0, 11'h100});
        bus_on <= 1'b1;
        apb(1'b1, bfp_pkg::ADDR_IRQ_MASK, 32'h1);
        repeat (300) @(posedge clk_sys);
        bus_on <= 1'b0;
        wait_park;
        chk(bfp_motion_model_inst.log_q.size(), 32'h3);
        chk_mv(0, 1'b0, 1'b1, bfp_pkg::HALF_RANGE_STEPS);
        chk_mv(1, 1'b0, 1'b1, bfp_pkg::CONFIRM_STEPS);
        chk_mv(2, 1'b1, 1'b0, 16'h0100);
        chk(bfp_motion_model_inst.n_zero, 32'h1);
        chk({31'h0, bus_lost}, 32'h1);
        chk({30'h0, sleep_req, stop_req}, 32'h2);
        apb(1'b0, bfp_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, bfp_pkg::ADDR_IRQ_STAT, 32'h1);
        apb(1'b0, bfp_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        $display("normal reference test done");
        restart({1'b1, 1'b1, 1'b0, 11'h100});
        bus_on <= 1'b1;
        repeat (300) @(posedge clk_sys);
        apb(1'b0, bfp_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h0);
        dual_cmd <= 1'b1;
        @(posedge clk_sys);
        dual_cmd <= 1'b0;
        apb(1'b1, bfp_pkg::ADDR_SAFE_POS, 32'h123);
        apb(1'b0, bfp_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        bfp_motion_model_inst.log_q.delete();
        bfp_motion_model_inst.tgt_q.delete();
        strap <= 1'b1;
        wait_park;
        chk_mv(0, 1'b1, 1'b0, 16'h0123);
        chk({30'h0, sleep_req, stop_req}, 32'h1);
        strap <= 1'b0;
        repeat (300) @(posedge clk_sys);
        bfp_motion_model_inst.log_q.delete();
        bfp_motion_model_inst.tgt_q.delete();
        bus_on <= 1'b0;
        wait_park;
        chk(bfp_motion_model_inst.log_q.size(), 32'h1);
        chk_mv(0, 1'b1, 1'b0, 16'h0123);
        chk({30'h0, sleep_req, stop_req}, 32'h2);
        bus_on <= 1'b1;
        repeat (300) @(posedge clk_sys);
        apb(1'b1, bfp_pkg::ADDR_SAFE_POS, 32'h400);
        bfp_motion_model_inst.log_q.delete();
        bus_on <= 1'b0;
        wait_park;
        chk(bfp_motion_model_inst.log_q.size(), 32'h0);
        $display("referenced and strap test done");
        wrap_up;
    end
    // Watchdog well beyond the five silence periods of the run
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
